// file: rtl/pmrc_map.vh
// Constants for the power mode rail control block
`ifndef PMRC_MAP_VH
`define PMRC_MAP_VH
`define PMRC_CLK_MHZ       100
`define PMRC_CH1_DLY_US    2000
`define PMRC_CH3_DLY_US    4000
`define PMRC_CH2_DLY_US    2000
`define PMRC_CH567_DLY_US  4000
`define PMRC_RST_DLY_US    4000
`define PMRC_ST_OFF        3'h0
`define PMRC_ST_CH4        3'h1
`define PMRC_ST_RAMP       3'h2
`define PMRC_ST_RUN        3'h3
`define PMRC_CH_NONE       7'h00
`define PMRC_CH_ALL        7'h7f
`define PMRC_CH_HOLD       7'h0b
`define PMRC_CH_EN         7'h74
`define PMRC_CH1_BIT       0
`define PMRC_CH2_BIT       1
`define PMRC_CH3_BIT       2
`define PMRC_CH4_BIT       3
`endif

// file: rtl/pmrc_rail_ctrl.v
// Power mode rail control: mode decision, power-up order, reset output
//
// How it works
// [R01] Hold and enable both high: all rails on
// [R02] Hold only: rails 1,2,4 on, rest off
// [R03] Neither hold nor enable: all rails off
// [R04] Button enables all rails regardless of pins
// [R05] Enable drives 3,5,6,7; hold drives 1,2,4
// [R06] Status pin pulled low while button pressed
// [R07] Rail 1 after 2ms, rail 3 after 4ms
// [R08] Release without hold aborts power-up, all off
// [R09] Button press drives reset low until timeout
// [R10] Hold, enable, button inputs pass two flops
`timescale 1ns/1ns
`include "pmrc_map.vh"
module pmrc_rail_ctrl
#(
   parameter CH1_CYC   = `PMRC_CH1_DLY_US * `PMRC_CLK_MHZ,
   parameter CH3_CYC   = `PMRC_CH3_DLY_US * `PMRC_CLK_MHZ,
   parameter CH2_CYC   = `PMRC_CH2_DLY_US * `PMRC_CLK_MHZ,
   parameter CH567_CYC = `PMRC_CH567_DLY_US * `PMRC_CLK_MHZ,
   parameter RST_CYC   = `PMRC_RST_DLY_US * `PMRC_CLK_MHZ
)
(
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_resetn,
   // Processor control pins
   input  wire       i_power_hold_in,
   input  wire       i_power_enable_in,
   input  wire       i_push_button_in_n,
   // Power good of rails four and three
   input  wire       i_ch4_good,
   input  wire       i_ch3_good,
   // Rail enables, bit 0 is channel one
   output reg  [6:0] o_channel_en,
   // Open-drain status and reset pins
   output reg        o_button_status_out,
   output reg        o_button_status_out_oe,
   output reg        o_processor_reset_out,
   output reg        o_processor_reset_out_oe
);

   // The delay counters saturate, so a rail that stays good never
   // wraps back below a threshold; 24 bits cover the longest delay
   // at the default clock with room to spare.
   localparam CW = 24;                 // Delay counter width

   // Every pin passes two flops; only the second one is read, so a
   // metastable first stage never reaches the sequencer.
   reg  [1:0]    hold_s_q;             // Hold synchroniser
   reg  [1:0]    en_s_q;               // Enable synchroniser
   reg  [1:0]    btn_s_q;              // Button synchroniser, active low
   reg  [1:0]    g4_s_q;               // Rail four good synchroniser
   reg  [1:0]    g3_s_q;               // Rail three good synchroniser
   reg  [2:0]    state_q;              // Sequencer state
   reg  [2:0]    state_d;
   // Power-up timers and the reset timeout share one width
   reg  [CW-1:0] t4_q;                 // Time rail four has been good
   reg  [CW-1:0] t3_q;                 // Time rail three has been good
   reg  [CW-1:0] rst_q;                // Reset timeout counter
   // Rail sets, bit 0 is channel one
   reg  [6:0]    ramp_q;               // Rails raised by power-up order
   reg  [6:0]    ramp_d;
   reg  [6:0]    chan_d;

   // Synchronised, active-high views of the pins
   wire hold    = hold_s_q[1];
   wire enable  = en_s_q[1];
   wire pressed = ~btn_s_q[1];
   wire good4   = g4_s_q[1];
   wire good3   = g3_s_q[1];

   // Mode mask from the two processor pins
   function [6:0] mode_mask;
      input h;
      input e;
      begin
         mode_mask = (h ? `PMRC_CH_HOLD : `PMRC_CH_NONE) |   // R05
                     (e ? `PMRC_CH_EN : `PMRC_CH_NONE);      // R05
      end
   endfunction

   // Two-flop synchronisers on every pin input
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         // Pins idle: button released, everything else low
         hold_s_q <= 2'h0;
         en_s_q   <= 2'h0;
         btn_s_q  <= 2'h3;
         g4_s_q   <= 2'h0;
         g3_s_q   <= 2'h0;
      end
      else
      begin
         hold_s_q <= {hold_s_q[0], i_power_hold_in};       // R10
         en_s_q   <= {en_s_q[0], i_power_enable_in};       // R10
         btn_s_q  <= {btn_s_q[0], i_push_button_in_n};     // R10
         g4_s_q   <= {g4_s_q[0], i_ch4_good};
         g3_s_q   <= {g3_s_q[0], i_ch3_good};
      end
   end

   // Sequencer next state and power-up rail set
   always @*
   begin
      state_d = state_q;
      ramp_d  = ramp_q;
      case (state_q)
         `PMRC_ST_OFF:
         begin
            ramp_d = `PMRC_CH_NONE;
            // Button press starts power-up with rail four
            if (pressed)
               state_d = `PMRC_ST_CH4;                     // R04
         end
         `PMRC_ST_CH4, `PMRC_ST_RAMP:
         begin
            // Rail four first, the rest follow the good timers
            ramp_d[`PMRC_CH4_BIT] = 1'b1;
            if (good4)
               state_d = `PMRC_ST_RAMP;
            // Rails one and three wait on rail four good
            if (t4_q >= CH1_CYC[CW-1:0])
               ramp_d[`PMRC_CH1_BIT] = 1'b1;               // R07
            if (t4_q >= CH3_CYC[CW-1:0])
               ramp_d[`PMRC_CH3_BIT] = 1'b1;               // R07
            // Rails two, five, six and seven wait on rail three good
            if (t3_q >= CH2_CYC[CW-1:0])
               ramp_d[`PMRC_CH2_BIT] = 1'b1;
            if (t3_q >= CH567_CYC[CW-1:0])
               ramp_d = `PMRC_CH_ALL;
            // Released without hold: abort; with hold: pins rule
            if (!pressed)
               state_d = hold ? `PMRC_ST_RUN : `PMRC_ST_OFF; // R08
         end
         `PMRC_ST_RUN:
         begin
            // Power-up done; the pins now own the rails
            ramp_d = `PMRC_CH_NONE;
            // Both pins low: system off
            if (!hold && !enable && !pressed)
               state_d = `PMRC_ST_OFF;                     // R03
         end
         // Unused codes fall back to off
         default:
            state_d = `PMRC_ST_OFF;
      endcase
   end

   // Rail enables from mode, button and power-up order
   always @*
   begin
      // Off state keeps every rail down
      chan_d = `PMRC_CH_NONE;
      if (state_q == `PMRC_ST_RUN)
      begin
         // Normal, sleep or off from the pins
         chan_d = mode_mask(hold, enable);                 // R01 R02 R03
         if (pressed)
            chan_d = `PMRC_CH_ALL;                         // R04
      end
      // Power-up: sequenced rails plus whatever the pins ask for
      else if (state_q != `PMRC_ST_OFF)
         chan_d = ramp_d | mode_mask(hold, enable);
   end

   // State, timers and registered outputs
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         // Rails off, processor held in reset
         state_q                  <= `PMRC_ST_OFF;
         ramp_q                   <= `PMRC_CH_NONE;
         t4_q                     <= {CW{1'b0}};
         t3_q                     <= {CW{1'b0}};
         rst_q                    <= {CW{1'b0}};
         o_channel_en             <= `PMRC_CH_NONE;
         o_button_status_out      <= 1'b0;
         o_button_status_out_oe   <= 1'b0;
         o_processor_reset_out    <= 1'b0;
         o_processor_reset_out_oe <= 1'b1;
      end
      else
      begin
         // Sequencer state and registered rail enables
         state_q      <= state_d;
         ramp_q       <= ramp_d;
         o_channel_en <= chan_d;
         // Time since rail four, then rail three, became good
         if (!good4 || state_q == `PMRC_ST_OFF)
            t4_q <= {CW{1'b0}};
         else if (t4_q != {CW{1'b1}})
            t4_q <= t4_q + 1'b1;
         // Rail three timer restarts whenever the rail drops
         if (!good3 || state_q == `PMRC_ST_OFF)
            t3_q <= {CW{1'b0}};
         else if (t3_q != {CW{1'b1}})
            t3_q <= t3_q + 1'b1;
         // Status pin low while the button is held
         o_button_status_out    <= 1'b0;
         o_button_status_out_oe <= pressed;                // R06
         // The reset pin is held while the button is down or rail four
         // is not good, so a manual reset and a brown-out both restart
         // the full timeout once the cause has gone away.
         // Reset low on press, on missing rail four, until timeout
         o_processor_reset_out <= 1'b0;
         if (pressed || !good4)
         begin
            rst_q                    <= {CW{1'b0}};        // R09
            o_processor_reset_out_oe <= 1'b1;              // R09
         end
         // Timeout reached: let the processor run
         else if (rst_q >= RST_CYC[CW-1:0])
            o_processor_reset_out_oe <= 1'b0;              // R09
         else
            rst_q <= rst_q + 1'b1;
      end
   end

endmodule

// file: verif/pmrc_rail_ctrl_sva.sv
// Assertion checker for the power mode rail control block
`timescale 1ns/1ns
module pmrc_rail_ctrl_sva
#(
   parameter CH1_CYC = 10,
   parameter CH3_CYC = 20
)
(
   // Clock and reset
   input wire       i_clk,
   input wire       i_resetn,
   // Processor control pins
   input wire       i_power_hold_in,
   input wire       i_power_enable_in,
   input wire       i_push_button_in_n,
   // Power good of rail four
   input wire       i_ch4_good,
   // Rail enables
   input wire [6:0] o_channel_en,
   // Open-drain status and reset pins
   input wire       o_button_status_out,
   input wire       o_button_status_out_oe,
   input wire       o_processor_reset_out,
   input wire       o_processor_reset_out_oe
);
   int  g4_q;                                   // Cycles rail four good
   wire h = i_power_hold_in;                    // Hold pin
   wire e = i_power_enable_in;                  // Enable pin
   wire b = i_push_button_in_n;                 // Button released
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Count how long rail four has been good
   always @(posedge i_clk or negedge i_resetn)
      if (!i_resetn)
         g4_q <= 0;
      else
         g4_q <= i_ch4_good ? g4_q + 1 : 0;
   AST_STAT_LOW: assert property (!b [*5] |-> o_button_status_out_oe)
      else $error("status not pulled low while pressed");
   AST_STAT_REL: assert property (b [*5] |-> !o_button_status_out_oe)
      else $error("status not released");
   AST_STAT_DAT: assert property (!o_button_status_out)
      else $error("status data not low");
   AST_RST_LOW: assert property (!b [*5] |-> o_processor_reset_out_oe)
      else $error("reset not held while pressed");
   AST_RST_DAT: assert property (!o_processor_reset_out)
      else $error("reset data not low");
   AST_NORMAL: assert property ((h && e && b) [*6] |->
      o_channel_en == 7'h00 || o_channel_en == 7'h7f)
      else $error("normal mode rails wrong");
   AST_SLEEP: assert property ((h && !e && b) [*6] |->
      o_channel_en == 7'h00 || o_channel_en == 7'h0b)
      else $error("sleep mode rails wrong");
   AST_OFF: assert property ((!h && !e && b) [*6] |-> o_channel_en == 0)
      else $error("rails not off");
   AST_EN_ONLY: assert property ((!h && e && b) [*6] |->
      o_channel_en == 7'h00 || o_channel_en == 7'h74)
      else $error("enable-only rails wrong");
   AST_CH1: assert property ($rose(o_channel_en[0]) && !h |->
      g4_q >= CH1_CYC)
      else $error("rail one early");
   AST_CH3: assert property ($rose(o_channel_en[2]) && !e |->
      g4_q >= CH3_CYC)
      else $error("rail three early");
   cover property ($rose(o_channel_en[0]));
   cover property (o_channel_en == 7'h0b);
   cover property ($fell(o_processor_reset_out_oe));
endmodule

// file: verif/pmrc_rail_model.sv
// Partner model: power-good report of rails four and three
`timescale 1ns/1ns
module pmrc_rail_model
#(
   parameter DLY = 3
)
(
   input  wire       i_clk,
   input  wire [6:0] i_channel_en,
   output logic      o_ch4_good = 1'b0,
   output logic      o_ch3_good = 1'b0
);
   int t4_q = 0;                                // Rail four ramp time
   int t3_q = 0;                                // Rail three ramp time
   // Good after ramp, drops at once when the rail is disabled
   always @(posedge i_clk)
   begin
      t4_q <= i_channel_en[3] ? t4_q + 1 : 0;
      t3_q <= i_channel_en[2] ? t3_q + 1 : 0;
      o_ch4_good <= i_channel_en[3] && t4_q >= DLY;
      o_ch3_good <= i_channel_en[2] && t3_q >= DLY;
   end
endmodule

// file: verif/testbench.sv
// Testbench for the power mode rail control block
`timescale 1ns/1ns
module testbench;
   logic       clk = 0, rstn = 0, hold = 0, en = 0, btn_n = 1;
   wire        g4, g3, st, st_oe, rs, rs_oe;
   wire  [6:0] ch;
   int         err_total = 0, n_checks = 0;
   pmrc_rail_ctrl #(.CH1_CYC(10), .CH3_CYC(20), .CH2_CYC(10),
      .CH567_CYC(20), .RST_CYC(30)) dut (.i_clk(clk), .i_resetn(rstn),
      .i_power_hold_in(hold), .i_power_enable_in(en),
      .i_push_button_in_n(btn_n), .i_ch4_good(g4), .i_ch3_good(g3),
      .o_channel_en(ch), .o_button_status_out(st),
      .o_button_status_out_oe(st_oe), .o_processor_reset_out(rs),
      .o_processor_reset_out_oe(rs_oe));
   pmrc_rail_model model (.i_clk(clk), .i_channel_en(ch),
      .o_ch4_good(g4), .o_ch3_good(g3));
   initial forever #5 clk = ~clk;
   // Compare a result with its expected value
   task chk(input logic [6:0] got, input logic [6:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare the four open-drain pin bits with their expected value
   task chk_pins(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Set pins at a falling edge, then wait n cycles
   task pins(input logic h, input logic e, input logic b, input int n);
      @(negedge clk);
      hold = h;
      en = e;
      btn_n = b;
      repeat (n) @(negedge clk);
   endtask
   // Short press without hold, then pins while off
   task t_abort;
      pins(0, 0, 0, 8);
      chk(ch & 7'h08, 7'h08);
      pins(0, 0, 1, 8);
      chk(ch, 7'h00);
      pins(1, 1, 1, 8);
      chk(ch, 7'h00);
   endtask
   // Full power-up with processor taking hold
   task t_powerup;
      pins(0, 0, 0, 0);
      for (int i = 0; i < 300 && ch[0] !== 1'b1; i++) @(negedge clk);
      chk(ch & 7'h05, 7'h01);
      for (int i = 0; i < 300 && ch !== 7'h7f; i++) @(negedge clk);
      chk(ch, 7'h7f);
      chk_pins({rs, st, rs_oe, st_oe}, 4'h3);
      pins(1, 1, 0, 4);
      pins(1, 1, 1, 8);
      chk(ch, 7'h7f);
      chk_pins({rs, st, rs_oe, st_oe}, 4'h2);
      pins(1, 1, 1, 40);
      chk_pins({rs, st, rs_oe, st_oe}, 4'h0);
   endtask
   // Sleep, enable alone, press in sleep, then off
   task t_modes;
      pins(1, 0, 1, 8);
      chk(ch, 7'h0b);
      pins(0, 1, 1, 8);
      chk(ch, 7'h74);
      pins(1, 0, 0, 8);
      chk(ch, 7'h7f);
      chk_pins({rs, st, rs_oe, st_oe}, 4'h3);
      pins(1, 0, 1, 8);
      chk(ch, 7'h0b);
      pins(0, 0, 1, 8);
      chk(ch, 7'h00);
   endtask
   // Print the verdict and end the run
   task stop_test;
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      rstn = 1;
      t_abort;
      t_powerup;
      t_modes;
      stop_test;
   end
   // Watchdog: the scenarios need about 200 cycles, allow ten times that
   initial
   begin
      #20000;
      err_total++;
      stop_test;
   end
endmodule
bind pmrc_rail_ctrl pmrc_rail_ctrl_sva #(
   .CH1_CYC                  (CH1_CYC),
   .CH3_CYC                  (CH3_CYC)
) u_sva (
   .i_clk                    (i_clk),
   .i_resetn                 (i_resetn),
   .i_power_hold_in          (i_power_hold_in),
   .i_power_enable_in        (i_power_enable_in),
   .i_push_button_in_n       (i_push_button_in_n),
   .i_ch4_good               (i_ch4_good),
   .o_channel_en             (o_channel_en),
   .o_button_status_out      (o_button_status_out),
   .o_button_status_out_oe   (o_button_status_out_oe),
   .o_processor_reset_out    (o_processor_reset_out),
   .o_processor_reset_out_oe (o_processor_reset_out_oe)
);
